// ===== logic/rx_gain_pkg.sv
// Purpose: shared constants and types for the receive gain sequencer
// Assumes: 25 MHz reference clock
// Notes: times kept in ns, cycle counts derived from them
package rx_gain_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int OSC_CAL_NS = 2200000;
    localparam int LEAK_CAL_NS = 20000;
    localparam int RETURN_MAX_NS = 3000;
    localparam int ENTRY_SETTLE_NS = 5000;
    localparam int HOLD_100K_NS = 5000;
    localparam int SHORT_PULSE_NS = 1000;
    localparam int SETTLE_BUDGET_NS = 8000;
    localparam int RAMP_UP_NS = 500;
    // Longest times round down, least times round up
    localparam int OSC_CAL_CYCLES = OSC_CAL_NS / CLK_PERIOD_NS;
    localparam logic [15:0] LEAK_CAL_CYCLES = 16'(LEAK_CAL_NS / CLK_PERIOD_NS);
    localparam logic [7:0] RETURN_MAX_CYCLES = 8'(RETURN_MAX_NS / CLK_PERIOD_NS);
    localparam logic [7:0] ENTRY_SETTLE_CYCLES =
        8'((ENTRY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] HOLD_100K_CYCLES =
        8'((HOLD_100K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SHORT_PULSE_CYCLES = SHORT_PULSE_NS / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_BUDGET_CYCLES = 8'(SETTLE_BUDGET_NS / CLK_PERIOD_NS);
    localparam logic [7:0] RAMP_UP_CYCLES =
        8'((RAMP_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0] GAIN_CEIL_HI = 7'h55;
    localparam logic [6:0] GAIN_CEIL_LO = 7'h36;
    localparam logic [6:0] GAIN_FLOOR = 7'h00;
    localparam logic signed [3:0] TRIM_MAX = 4'sh7;
    localparam logic signed [3:0] TRIM_MIN = 4'sh9;
    typedef enum logic [1:0] {notch_10m, notch_1m, notch_100k, notch_10k} notch_t;
    typedef enum logic [2:0] {
        sleep_mode,
        wait_mode,
        pin_switched_mode,
        manual_receive_gain_mode,
        osc_band_calibration_mode,
        carrier_leak_calibration_mode
    } chip_mode_t;
    typedef struct packed {
        logic [6:0] max_gain_ceiling;
        logic signed [3:0] target_trim;
        logic [7:0] step_wait;
        logic [6:0] manual_gain;
        notch_t manual_notch;
    } rx_cfg_t;
    typedef struct packed {
        logic [7:0] ramp_delay;
        logic digital_input;
    } tx_cfg_t;
    typedef struct packed {
        logic data_i;
        logic data_q;
    } iq_bits_t;
endpackage

// ===== logic/request_pulse_meter.sv
// Purpose: synchronise the settle request pin and measure its high width
// Assumes: pin asynchronous to clk
// Notes: width saturates, so only short versus long is meaningful
`timescale 1ns/1ps
module request_pulse_meter
    import rx_gain_pkg::*;
#(
    parameter int SHORT_CYCLES = SHORT_PULSE_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pin
    input wire logic pin,
    // Events
    output logic req_level,
    output logic req_rise,
    output logic short_fall
);
    if (SHORT_CYCLES < 1 || SHORT_CYCLES > 254)
    begin : g_chk
        $error("SHORT_CYCLES out of range");
    end
    logic meta;
    logic req_q;
    logic [7:0] width;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta <= 1'b0;
            req_level <= 1'b0;
            req_q <= 1'b0;
        end
        else
        begin
            meta <= pin;
            req_level <= meta;
            req_q <= req_level;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            width <= 8'h00;
        else if (req_level && !req_q)
            width <= 8'h01;
        else if (req_level && width != 8'hff)
            width <= width + 8'h01;
    end

    assign req_rise = req_level && !req_q;
    // A request held for more than SHORT_CYCLES cycles is never short
    assign short_fall = !req_level && req_q && (width <= 8'(SHORT_CYCLES));
endmodule

// ===== logic/tx_ramp_timer.sv
// Purpose: delay then fixed-length power ramp on entering transmit
// Assumes: tx_active is synchronous to clk
// Notes: the delay is programmable, the ramp length is not
`timescale 1ns/1ps
module tx_ramp_timer
    import rx_gain_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic tx_active,
    input wire logic [7:0] ramp_delay,
    // Status
    output logic ramp_on,
    output logic ramp_done
);
    typedef enum logic [1:0] {r_idle, r_delay, r_ramp, r_full} ramp_state_t;
    ramp_state_t rstate;
    logic [7:0] cnt;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstate <= r_idle;
            cnt <= 8'h00;
        end
        else if (!tx_active)
        begin
            // Leaving transmit relies on this clock still running
            rstate <= r_idle;
            cnt <= 8'h00;
        end
        else
        begin
            cnt <= cnt + 8'h01;
            unique case (rstate)
                r_idle:
                begin
                    rstate <= r_delay;
                    cnt <= 8'h00;
                end
                r_delay:
                    if (cnt >= ramp_delay)
                    begin
                        rstate <= r_ramp;
                        cnt <= 8'h00;
                    end
                r_ramp:
                    if (cnt == RAMP_UP_CYCLES - 8'h01)
                        rstate <= r_full;
                r_full:
                    cnt <= cnt;
            endcase
        end
    end

    assign ramp_on = (rstate == r_ramp) || (rstate == r_full);
    assign ramp_done = (rstate == r_full);
endmodule

// ===== logic/rx_gain_settling_sequencer.sv
// Purpose: receive gain settling, notch stepping, mode exits, transmit controls
// Assumes: mode and config come from the bus logic on clk; pins are asynchronous
// Notes: signal_strength_value is a dB error vs nominal, sampled on clk
// Overview of operation
// - Oscillator calibration ends within 2.2 ms, then sleep
// - Notch cutoff is 10M, 1M, 100k or 10k
// - Settling alternates notch between 10 MHz and 1 MHz
// - After settling, 100 kHz for 5 us, then 10 kHz
// - Manual mode uses programmed gain and notch
// - Receive entry sets ceiling gain and 1 MHz notch
// - Gain steps down to target within 8 us
// - Wait after each gain step is programmable
// - Settled flag rises; gain frozen until next request
// - Request rise clears flag and starts cycle
// - Not at maximum: 3 us return first, 11 us total
// - Short pulse forces maximum gain, no flag
// - Settling target trimmable by plus or minus 7 dB
// - Ceiling 54 to 85 dB, never altered by loop
// - Only manual mode exceeds ceiling, ceiling unchanged
// - Leak calibration refused while digital transmit input used
// - Digital I and Q streams sampled on clock
// - Power select pin picks high or low port
// - Programmable delay before fixed-length power ramp
// - Pin-switched mode: one transmits, zero receives
// - Leak calibration ends within 20 us, then sleep
`timescale 1ns/1ps
module rx_gain_settling_sequencer
    import rx_gain_pkg::*;
#(
    parameter int OSC_CAL_LEN = OSC_CAL_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Mode selection from the bus logic
    input wire logic mode_write,
    input wire chip_mode_t mode_value,
    input wire logic synth_reload_write,
    input wire rx_cfg_t rx_cfg,
    input wire tx_cfg_t tx_cfg,
    // Pins
    input wire logic gain_settle_request,
    input wire logic tx_rx_select,
    input wire logic high_power_output_select,
    input wire iq_bits_t tx_data,
    input wire logic signed [5:0] signal_strength_value,
    // Mode status
    output chip_mode_t chip_mode,
    output logic synth_reload_needed,
    output logic leak_cal_refused,
    // Receive side
    output logic gain_settled_flag,
    output logic [6:0] rx_gain,
    output notch_t notch_sel,
    output logic rx_enable,
    // Transmit side
    output logic tx_enable,
    output logic high_port_en,
    output logic low_port_en,
    output logic tx_power_ramp_on,
    output logic tx_ramp_done,
    output iq_bits_t tx_sample,
    output logic tx_sample_valid
);
    if (OSC_CAL_LEN < 1 || OSC_CAL_LEN > 65535)
    begin : g_chk
        $error("OSC_CAL_LEN out of range");
    end

    typedef enum logic [2:0] {
        g_max, g_entry, g_return, g_fast, g_fine, g_hold, g_frozen
    } gain_state_t;

    function automatic logic [6:0] clamp_ceiling(input logic [6:0] v);
        if (v > GAIN_CEIL_HI)
            return GAIN_CEIL_HI;
        else if (v < GAIN_CEIL_LO)
            return GAIN_CEIL_LO;
        else
            return v;
    endfunction

    function automatic logic signed [3:0] clamp_trim(input logic signed [3:0] v);
        if (v > TRIM_MAX)
            return TRIM_MAX;
        else if (v < TRIM_MIN)
            return TRIM_MIN;
        else
            return v;
    endfunction

    // Pin synchronisers for the two mode pins
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic tx_rx_s;
    logic hp_s;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end
        else
        begin
            pin_meta <= {high_power_output_select, tx_rx_select};
            pin_sync <= pin_meta;
        end
    end
    assign tx_rx_s = pin_sync[0];
    assign hp_s = pin_sync[1];

    // Mode register and calibration timers
    logic [15:0] cal_cnt;
    logic osc_done;
    logic leak_done;
    logic leak_reject;

    assign osc_done = (chip_mode == osc_band_calibration_mode)
        && (cal_cnt == 16'(OSC_CAL_LEN - 1));
    assign leak_done = (chip_mode == carrier_leak_calibration_mode)
        && (cal_cnt == LEAK_CAL_CYCLES - 16'h0001);
    assign leak_reject = mode_write && tx_cfg.digital_input
        && (mode_value == carrier_leak_calibration_mode);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            chip_mode <= sleep_mode;
            cal_cnt <= 16'h0000;
        end
        else if (mode_write && !leak_reject)
        begin
            chip_mode <= mode_value;
            cal_cnt <= 16'h0000;
        end
        else if (osc_done || leak_done)
        begin
            chip_mode <= sleep_mode;
            cal_cnt <= 16'h0000;
        end
        else if (chip_mode == osc_band_calibration_mode
            || chip_mode == carrier_leak_calibration_mode)
            cal_cnt <= cal_cnt + 16'h0001;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            leak_cal_refused <= 1'b0;
        else if (leak_reject)
            leak_cal_refused <= 1'b1;
        else if (mode_write)
            leak_cal_refused <= 1'b0;
    end

    // Completion wins over a reload write in the same cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            synth_reload_needed <= 1'b0;
        else if (osc_done)
            synth_reload_needed <= 1'b1;
        else if (synth_reload_write)
            synth_reload_needed <= 1'b0;
    end

    // Receive direction and entry detection
    logic rx_auto;
    logic rx_manual;
    logic rx_on_q;
    logic rx_entry;
    logic [6:0] ceiling;
    logic signed [3:0] trim;

    assign rx_auto = (chip_mode == pin_switched_mode) && !tx_rx_s;
    assign rx_manual = (chip_mode == manual_receive_gain_mode);
    assign rx_entry = (rx_auto || rx_manual) && !rx_on_q;
    assign ceiling = clamp_ceiling(rx_cfg.max_gain_ceiling);
    assign trim = clamp_trim(rx_cfg.target_trim);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rx_on_q <= 1'b0;
        else
            rx_on_q <= rx_auto || rx_manual;
    end

    // Gain loop
    logic req_level;
    logic req_rise;
    logic short_fall;
    gain_state_t gstate;
    logic [6:0] auto_gain;
    logic [7:0] gcnt;
    logic [7:0] budget;
    logic pending;
    logic settling;
    logic wait_over;
    logic budget_out;
    logic reduce;
    logic settle_done;

    request_pulse_meter #(.SHORT_CYCLES(SHORT_PULSE_CYCLES)) u_meter (
        .clk(clk),
        .nrst(nrst),
        .pin(gain_settle_request),
        .req_level(req_level),
        .req_rise(req_rise),
        .short_fall(short_fall)
    );

    assign settling = (gstate == g_fast) || (gstate == g_fine);
    assign wait_over = (gcnt >= rx_cfg.step_wait);
    assign budget_out = (budget == SETTLE_BUDGET_CYCLES - 8'h01);
    assign reduce = (signal_strength_value > 6'(trim)) && (auto_gain > GAIN_FLOOR);
    assign settle_done = rx_auto && !rx_entry && !req_rise && !short_fall && settling
        && (budget_out || (gstate == g_fine && wait_over && !reduce));

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gstate <= g_max;
            auto_gain <= GAIN_CEIL_HI;
            gcnt <= 8'h00;
            budget <= 8'h00;
            pending <= 1'b0;
        end
        else if (rx_entry)
        begin
            auto_gain <= ceiling;
            gstate <= g_entry;
            gcnt <= 8'h00;
            pending <= 1'b0;
        end
        else if (rx_auto)
        begin
            gcnt <= gcnt + 8'h01;
            if (short_fall)
            begin
                auto_gain <= ceiling;
                gstate <= g_return;
                gcnt <= 8'h00;
                pending <= 1'b0;
            end
            else if (req_rise)
            begin
                gcnt <= 8'h00;
                budget <= 8'h00;
                if (gstate == g_max)
                    gstate <= g_fast;
                else
                begin
                    auto_gain <= ceiling;
                    gstate <= g_return;
                    pending <= 1'b1;
                end
            end
            else if (settle_done)
            begin
                gstate <= g_hold;
                gcnt <= 8'h00;
            end
            else
            begin
                unique case (gstate)
                    g_max, g_frozen:
                        gcnt <= 8'h00;
                    g_entry:
                        if (gcnt == ENTRY_SETTLE_CYCLES - 8'h01)
                            gstate <= g_max;
                    g_return:
                        if (gcnt == RETURN_MAX_CYCLES - 8'h01)
                        begin
                            gstate <= pending ? g_fast : g_max;
                            pending <= 1'b0;
                            budget <= 8'h00;
                            gcnt <= 8'h00;
                        end
                    g_fast:
                    begin
                        budget <= budget + 8'h01;
                        if (wait_over)
                        begin
                            gstate <= g_fine;
                            gcnt <= 8'h00;
                        end
                    end
                    g_fine:
                    begin
                        budget <= budget + 8'h01;
                        if (wait_over)
                        begin
                            auto_gain <= auto_gain - 7'h01;
                            gstate <= g_fast;
                            gcnt <= 8'h00;
                        end
                    end
                    g_hold:
                        if (gcnt == HOLD_100K_CYCLES - 8'h01)
                            gstate <= g_frozen;
                endcase
            end
        end
    end

    // Neither a rise nor a short fall can coincide with completion, so no clear masks a set
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            gain_settled_flag <= 1'b0;
        else if (rx_entry || req_rise)
            gain_settled_flag <= 1'b0;
        else if (short_fall)
            gain_settled_flag <= 1'b0;
        else if (settle_done)
            gain_settled_flag <= 1'b1;
    end

    // Registered gain and notch outputs
    logic [6:0] next_gain;
    notch_t next_notch;

    always_comb
    begin
        next_gain = auto_gain;
        next_notch = notch_1m;
        if (rx_manual)
        begin
            next_gain = rx_cfg.manual_gain;
            next_notch = rx_cfg.manual_notch;
        end
        else
        begin
            unique case (gstate)
                g_fast: next_notch = notch_10m;
                g_hold: next_notch = notch_100k;
                g_frozen: next_notch = notch_10k;
                default: next_notch = notch_1m;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_gain <= GAIN_CEIL_HI;
            notch_sel <= notch_1m;
            rx_enable <= 1'b0;
        end
        else
        begin
            rx_gain <= next_gain;
            notch_sel <= next_notch;
            rx_enable <= rx_auto || rx_manual;
        end
    end

    // Transmit side
    logic tx_active;
    assign tx_active = (chip_mode == pin_switched_mode) && tx_rx_s;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_enable <= 1'b0;
            high_port_en <= 1'b0;
            low_port_en <= 1'b0;
        end
        else
        begin
            tx_enable <= tx_active;
            high_port_en <= tx_active && hp_s;
            low_port_en <= tx_active && !hp_s;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_sample <= '0;
            tx_sample_valid <= 1'b0;
        end
        else
        begin
            tx_sample <= tx_data;
            tx_sample_valid <= tx_active && tx_cfg.digital_input;
        end
    end

    tx_ramp_timer u_ramp (
        .clk(clk),
        .nrst(nrst),
        .tx_active(tx_active),
        .ramp_delay(tx_cfg.ramp_delay),
        .ramp_on(tx_power_ramp_on),
        .ramp_done(tx_ramp_done)
    );

    // Checks
    property p_osc_exit;
        @(posedge clk) disable iff (!nrst)
        osc_done && !mode_write |=> chip_mode == sleep_mode;
    endproperty
    a_osc_exit: assert property (p_osc_exit) else $error("osc cal did not end");

    property p_leak_exit;
        @(posedge clk) disable iff (!nrst)
        leak_done && !mode_write |=> chip_mode == sleep_mode;
    endproperty
    a_leak_exit: assert property (p_leak_exit) else $error("leak cal did not end");

    property p_entry;
        @(posedge clk) disable iff (!nrst)
        rx_entry && rx_auto |=> ##1 rx_gain == $past(ceiling, 2) && notch_sel == notch_1m;
    endproperty
    a_entry: assert property (p_entry) else $error("entry not at ceiling");

    property p_rise_clears;
        @(posedge clk) disable iff (!nrst)
        req_rise && rx_auto |=> !gain_settled_flag;
    endproperty
    a_rise_clears: assert property (p_rise_clears) else $error("flag not cleared");

    property p_frozen;
        @(posedge clk) disable iff (!nrst)
        gstate == g_frozen && rx_auto && !req_rise && !short_fall && !rx_entry
            |=> auto_gain == $past(auto_gain);
    endproperty
    a_frozen: assert property (p_frozen) else $error("gain moved while settled");

    property p_hold;
        @(posedge clk) disable iff (!nrst)
        settle_done ##1 (rx_auto && !req_rise && !rx_entry && !short_fall)[*2]
            |-> notch_sel == notch_100k && gain_settled_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("no 100k hold");

    property p_short;
        @(posedge clk) disable iff (!nrst)
        short_fall && rx_auto && !rx_entry |=> gstate == g_return && !gain_settled_flag;
    endproperty
    a_short: assert property (p_short) else $error("short pulse mishandled");

    property p_ceiling;
        @(posedge clk) disable iff (!nrst)
        !rx_manual |=> rx_gain == $past(auto_gain) && rx_gain <= GAIN_CEIL_HI;
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("gain above ceiling");

    property p_budget;
        @(posedge clk) disable iff (!nrst)
        settling |-> budget < SETTLE_BUDGET_CYCLES;
    endproperty
    a_budget: assert property (p_budget) else $error("settling overran");

    property p_port;
        @(posedge clk) disable iff (!nrst)
        tx_active |=> high_port_en == $past(hp_s) && low_port_en == !$past(hp_s);
    endproperty
    a_port: assert property (p_port) else $error("wrong output port");
endmodule

// ===== dv/gain_request_host.sv
// Purpose: controller side of the gain handshake, drives the request pin
// Assumes: start is a one-cycle pulse, width counted in clk cycles
// Notes: pin stays low outside pulses, so no stale level is left
`timescale 1ns/1ps
module gain_request_host
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Command
    input wire logic start,
    input wire logic [7:0] width,
    // Pin
    output logic pin
);
    logic [7:0] left;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin <= 1'b0;
            left <= 8'h00;
        end
        else if (start && !pin)
        begin
            pin <= 1'b1;
            left <= width;
        end
        else if (left != 8'h00)
            left <= left - 8'h01;
        else
            pin <= 1'b0;
    end
endmodule

// ===== dv/rx_gain_settling_sequencer_bench.sv
// Purpose: random and corner checks of the gain sequencer
// Assumes: short calibration length for speed
// Notes: waits are bounded; checks run 1 ns after an edge
`timescale 1ns/1ps
`define chk(n,e,s) begin checks++; if ((s) !== (e)) begin fails++; \
    $display("wrong value %s exp %0h saw %0h", n, e, s); end end
`define wt(c,n) begin k = 0; while (!(c) && k < n) begin @(posedge clk); #1; k++; end \
    if (!(c)) begin fails++; wrap_up; end end
module rx_gain_settling_sequencer_bench;
    import rx_gain_pkg::*;
    logic clk = 0, nrst = 0, mode_write = 0, synth_reload_write = 0, tx_rx_select = 0;
    logic high_power_output_select = 0, start = 0, pin, synth_reload_needed, leak_cal_refused;
    logic gain_settled_flag, rx_enable, tx_enable, high_port_en, low_port_en;
    logic tx_power_ramp_on, tx_ramp_done, tx_sample_valid;
    logic signed [5:0] signal_strength_value = 0;
    logic [6:0] rx_gain, ceil, g;
    logic [7:0] width = 0;
    chip_mode_t mode_value = sleep_mode, chip_mode;
    rx_cfg_t rx_cfg;
    tx_cfg_t tx_cfg;
    iq_bits_t tx_data = 0, tx_sample, v;
    notch_t notch_sel;
    int fails = 0, checks = 0, k, seed = 32'h78d433e1;
    always #20 clk = ~clk;
    gain_request_host host (.clk(clk), .nrst(nrst), .start(start), .width(width), .pin(pin));
    rx_gain_settling_sequencer #(.OSC_CAL_LEN(50)) dut (.clk(clk), .nrst(nrst),
        .mode_write(mode_write), .mode_value(mode_value),
        .synth_reload_write(synth_reload_write), .rx_cfg(rx_cfg), .tx_cfg(tx_cfg),
        .gain_settle_request(pin), .tx_rx_select(tx_rx_select),
        .high_power_output_select(high_power_output_select), .tx_data(tx_data),
        .signal_strength_value(signal_strength_value), .chip_mode(chip_mode),
        .synth_reload_needed(synth_reload_needed), .leak_cal_refused(leak_cal_refused),
        .gain_settled_flag(gain_settled_flag), .rx_gain(rx_gain), .notch_sel(notch_sel),
        .rx_enable(rx_enable), .tx_enable(tx_enable), .high_port_en(high_port_en),
        .low_port_en(low_port_en), .tx_power_ramp_on(tx_power_ramp_on),
        .tx_ramp_done(tx_ramp_done), .tx_sample(tx_sample), .tx_sample_valid(tx_sample_valid));
    task automatic mw(chip_mode_t m);
        @(posedge clk);
        mode_write <= 1'b1;
        mode_value <= m;
        @(posedge clk);
        mode_write <= 1'b0;
        #1;
    endtask
    task automatic req(logic [7:0] w);
        @(posedge clk);
        start <= 1'b1;
        width <= w;
        @(posedge clk);
        start <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        fails++;
        wrap_up;
    end
    initial
    begin
        // Ceiling drawn across its whole legal span
        ceil = 7'(54 + {$random(seed)} % 32);
        rx_cfg = {ceil, 4'sh0, 8'h02, 7'h5a, notch_10m};
        tx_cfg = {8'h04, 1'b0};
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        #1;
        `chk("mode", sleep_mode, chip_mode)
        `chk("notch", notch_1m, notch_sel)
        mw(osc_band_calibration_mode);
        `chk("mode", osc_band_calibration_mode, chip_mode)
        `wt(chip_mode == sleep_mode, 60)
        `chk("reload", 1'b1, synth_reload_needed)
        @(posedge clk);
        synth_reload_write <= 1'b1;
        @(posedge clk);
        synth_reload_write <= 1'b0;
        #1;
        `chk("reload", 1'b0, synth_reload_needed)
        tx_cfg.digital_input <= 1'b1;
        mw(carrier_leak_calibration_mode);
        `chk("refused", 1'b1, leak_cal_refused)
        `chk("mode", sleep_mode, chip_mode)
        tx_cfg.digital_input <= 1'b0;
        mw(carrier_leak_calibration_mode);
        `chk("mode", carrier_leak_calibration_mode, chip_mode)
        `wt(chip_mode == sleep_mode, 510)
        mw(pin_switched_mode);
        `wt(rx_enable, 10)
        // Gain output is registered one cycle behind the enable
        @(posedge clk);
        #1;
        `chk("gain", ceil, rx_gain)
        `chk("notch", notch_1m, notch_sel)
        repeat (2)
        begin
            signal_strength_value <= 6'(1 + {$random(seed)} % 20);
            req(8'd130);
            `wt(!gain_settled_flag, 10)
            `wt(gain_settled_flag, 400)
            `chk("ceiling", 1'b1, rx_gain <= ceil)
            g = rx_gain;
            signal_strength_value <= 6'($random(seed));
            repeat (60) @(posedge clk);
            #1;
            `chk("notch", notch_100k, notch_sel)
            repeat (80) @(posedge clk);
            #1;
            `chk("notch", notch_10k, notch_sel)
            `chk("frozen", g, rx_gain)
        end
        req(8'd10);
        repeat (130) @(posedge clk);
        #1;
        `chk("flag", 1'b0, gain_settled_flag)
        `chk("gain", ceil, rx_gain)
        `chk("notch", notch_1m, notch_sel)
        // Short pulse at maximum gain: settling may finish early, flag must drop
        signal_strength_value <= -6'sd5;
        req(8'd10);
        repeat (100) @(posedge clk);
        #1;
        `chk("flag", 1'b0, gain_settled_flag)
        `chk("gain", ceil, rx_gain)
        req(8'd130);
        `wt(gain_settled_flag, 220)
        `chk("gain", ceil, rx_gain)
        mw(manual_receive_gain_mode);
        for (int n = 0; n < 4; n++)
        begin
            rx_cfg.manual_notch <= notch_t'(n);
            repeat (3) @(posedge clk);
            #1;
            `chk("notch", notch_t'(n), notch_sel)
            `chk("gain", 7'h5a, rx_gain)
        end
        tx_rx_select <= 1'b1;
        high_power_output_select <= 1'b1;
        tx_cfg.digital_input <= 1'b1;
        mw(pin_switched_mode);
        `wt(tx_enable, 10)
        repeat (3) @(posedge clk);
        #1;
        `chk("early", 1'b0, tx_power_ramp_on)
        `wt(tx_power_ramp_on, 10)
        `wt(tx_ramp_done, 16)
        `chk("hi", 1'b1, high_port_en)
        high_power_output_select <= 1'b0;
        `wt(low_port_en, 6)
        `chk("hi", 1'b0, high_port_en)
        repeat (4)
        begin
            v = 2'($random(seed));
            @(posedge clk);
            tx_data <= v;
            @(posedge clk);
            #1;
            `chk("sample", v, tx_sample)
            `chk("valid", 1'b1, tx_sample_valid)
        end
        wrap_up;
    end
endmodule
